// >>> src/kmlc_pkg.sv
// Constants shared by the keyboard/mouse logical device configuration block.
// Assumes an 8-bit index/data configuration port in front of it.
package kmlc_pkg;
  // ****************************************
  // Configuration port addressing
  // ****************************************
  localparam logic [7:0] KMLC_IDX_LDN    = 8'h07; // Logical device number register
  localparam logic [7:0] KMLC_LDN_KBD    = 8'h01; // This logical device's number
  localparam logic [7:0] KMLC_OFS_ISO    = 8'hf0; // isolation_latch_control
  localparam logic [7:0] KMLC_OFS_SWAP   = 8'hf1; // pin_swap_select
  localparam logic [7:0] KMLC_OFS_RST    = 8'hf2; // core_reset_control
  // ****************************************
  // Field positions
  // ****************************************
  localparam int KMLC_B_MISO   = 6; // Mouse isolate
  localparam int KMLC_B_KISO   = 5; // Keyboard isolate
  localparam int KMLC_B_MLSEL  = 4; // mouse_irq_latch_select
  localparam int KMLC_B_KLSEL  = 3; // keyboard_irq_latch_select
  localparam int KMLC_B_FGATE  = 2; // Fast gate port enable
  localparam int KMLC_B_SWAP   = 0; // Pin swap
  localparam int KMLC_B_CRST   = 0; // Core reset
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] KMLC_RST_BYTE = 8'h00; // All three registers
  localparam logic       KMLC_RST_BIT  = 1'b0;  // Single control bits
endpackage : kmlc_pkg

// >>> src/kmlc_chan_if.sv
// Signals between the top and one keyboard-or-mouse channel.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface kmlc_chan_if;
  logic pin_clk;   // Raw clock pin level
  logic pin_dat;   // Raw data pin level
  logic isolate;   // Block pins into the core
  logic latch_sel; // Interrupt latch select
  logic core_irq;  // Core interrupt
  logic irq_ack;   // Core's clear of the latched copy
  logic core_clk;  // Clock level toward the core
  logic core_dat;  // Data level toward the core
  logic wake_dat;  // Data level toward wakeup logic
  logic irq;       // Selected interrupt
  modport top  (output pin_clk, pin_dat, isolate, latch_sel, core_irq, irq_ack,
                input  core_clk, core_dat, wake_dat, irq);
  modport chan (input  pin_clk, pin_dat, isolate, latch_sel, core_irq, irq_ack,
                output core_clk, core_dat, wake_dat, irq);
endinterface : kmlc_chan_if

// >>> src/kmlc_chan.sv
// One PS/2 channel: pin synchroniser, isolation gate and interrupt latch.
// Assumes the top holds clock enable and reset; pins are asynchronous.
`timescale 1ns/1ps
module kmlc_chan
  import kmlc_pkg::*;
(
  input  wire logic  clk,   // 200 MHz clock
  input  wire logic  rst_n, // Host domain reset, synchronous
  input  wire logic  ce,    // Clock enable
  kmlc_chan_if.chan  ch     // Channel signals
);
  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic [1:0] meta_r; // First stage, read only by the second
  logic [1:0] sync_r; // Second stage: {clk, dat}
  logic       lat_r;  // Latched copy of the core interrupt

  // Two flops per pin before anything looks at it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
    end
    else if (ce)
    begin
      meta_r <= {ch.pin_clk, ch.pin_dat};
      sync_r <= meta_r;
    end
  end

  // Wakeup path bypasses the isolate gate entirely
  assign ch.wake_dat = sync_r[0];
  // Blocked pins read idle high so the core sees a quiet bus
  assign ch.core_clk = ch.isolate | sync_r[1];
  assign ch.core_dat = ch.isolate | sync_r[0];

  // ****************************************
  // Interrupt latch
  // ****************************************
  // Set by the core interrupt, cleared by the core's ack; set wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lat_r <= KMLC_RST_BIT;
    else if (ce)
    begin
      if (ch.core_irq)
        lat_r <= 1'b1;
      else if (ch.irq_ack)
        lat_r <= 1'b0;
    end
  end

  // Default ANDs the live line with its latch; select 1 gives the latch alone
  assign ch.irq = ch.latch_sel ? lat_r : (lat_r & ch.core_irq);

  // ****************************************
  // Checks
  // ****************************************
  chk_iso_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
    ch.isolate |-> (ch.core_clk && ch.core_dat))
    else $error("isolated channel not idle high");
  chk_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && ch.core_irq) |=> lat_r)
    else $error("latch missed core interrupt");
endmodule : kmlc_chan

// >>> src/kmlc_top.sv
// Keyboard/mouse logical device configuration registers and pin routing.
// Assumes an index/data configuration port on the same clock, a
// keyboard controller core beside it, and open-drain PS/2 pins.
//
// What this block does
// - Mouse isolate blocks mouse pins into core
// - Mouse wake data path ignores mouse isolate
// - Keyboard isolate blocks keyboard pins into core
// - Keyboard wake data path ignores keyboard isolate
// - Mouse interrupt: AND with latch, or latch
// - Keyboard interrupt: AND with latch, or latch
// - Fast gate port enabled only when set
// - Swap exchanges keyboard and mouse pin pairs
// - Wake events ignore isolate and swap settings
// - Core reset bit holds core in reset
// - Logical device number selects register bank
`timescale 1ns/1ps
module kmlc_top
  import kmlc_pkg::*;
(
  input  wire logic       clk,                  // 200 MHz clock
  input  wire logic       rst_n,                // Host domain reset, sync
  input  wire logic       standby_system_reset_n, // Standby reset, sync
  input  wire logic       ce,                   // Clock enable
  input  wire logic       cfg_wr,               // Port write strobe
  input  wire logic       cfg_rd,               // Port read strobe
  input  wire logic       cfg_sel_data,         // 0 index port, 1 data port
  input  wire logic [7:0] cfg_wdata,            // Write data
  output logic      [7:0] cfg_rdata,            // Read data
  input  wire logic       keyboard_clock_pin_in,  // Pin level
  input  wire logic       keyboard_data_pin_in,   // Pin level
  input  wire logic       mouse_clock_pin_in,     // Pin level
  input  wire logic       mouse_data_pin_in,      // Pin level
  output logic            keyboard_clock_pin_out, // Always low when driving
  output logic            keyboard_clock_pin_oe,  // High pulls pin low
  output logic            keyboard_data_pin_out,  // Always low when driving
  output logic            keyboard_data_pin_oe,   // High pulls pin low
  output logic            mouse_clock_pin_out,    // Always low when driving
  output logic            mouse_clock_pin_oe,     // High pulls pin low
  output logic            mouse_data_pin_out,     // Always low when driving
  output logic            mouse_data_pin_oe,      // High pulls pin low
  input  wire logic       core_kbd_clk_drive,   // Core pulls kbd clock low
  input  wire logic       core_kbd_dat_drive,   // Core pulls kbd data low
  input  wire logic       core_mse_clk_drive,   // Core pulls mouse clock low
  input  wire logic       core_mse_dat_drive,   // Core pulls mouse data low
  output logic            core_kbd_clk_in,      // Kbd clock to core
  output logic            core_kbd_dat_in,      // Kbd data to core
  output logic            core_mse_clk_in,      // Mouse clock to core
  output logic            core_mse_dat_in,      // Mouse data to core
  input  wire logic       core_keyboard_interrupt, // Core kbd interrupt
  input  wire logic       core_mouse_interrupt,    // Core mouse interrupt
  input  wire logic       core_kbd_irq_ack,     // Clears kbd latch
  input  wire logic       core_mouse_irq_ack,   // Clears mouse latch
  output logic            keyboard_interrupt,   // Selected kbd interrupt
  output logic            mouse_interrupt,      // Selected mouse interrupt
  output logic            keyboard_wake_data,   // Kbd data to wakeup logic
  output logic            mouse_wake_data,      // Mouse data to wakeup logic
  output logic            fast_gate_enable,     // Fast gate port enabled
  output logic            core_reset            // Holds core in reset
);
  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] index_r;  // Index port
  logic [7:0] ldn_r;    // Logical device number
  logic [1:0] iso_r;    // {mouse, keyboard} isolate, standby reset only
  logic [2:0] ctl_r;    // {mouse latch sel, kbd latch sel, fast gate}
  logic       swap_r;   // Pin swap
  logic       crst_r;   // Core reset

  // Address decode, all on named wires
  wire in_bank  = (ldn_r == KMLC_LDN_KBD);
  wire dat_wr   = cfg_wr && cfg_sel_data;
  wire wr_ldn   = dat_wr && (index_r == KMLC_IDX_LDN);
  wire wr_iso   = dat_wr && in_bank && (index_r == KMLC_OFS_ISO);
  wire wr_swap  = dat_wr && in_bank && (index_r == KMLC_OFS_SWAP);
  wire wr_rst   = dat_wr && in_bank && (index_r == KMLC_OFS_RST);
  // Reserved bits are not stored, so they read back zero whatever the host wrote
  wire [7:0] rd_iso  = {1'b0, iso_r, ctl_r, 2'b00};
  wire [7:0] rd_swap = {7'h00, swap_r};
  wire [7:0] rd_rst  = {7'h00, crst_r};
  wire [7:0] rd_mux  =
    !cfg_sel_data                                   ? index_r :
    (index_r == KMLC_IDX_LDN)                       ? ldn_r   :
    (in_bank && (index_r == KMLC_OFS_ISO))          ? rd_iso  :
    (in_bank && (index_r == KMLC_OFS_SWAP))         ? rd_swap :
    (in_bank && (index_r == KMLC_OFS_RST))          ? rd_rst  : 8'h00;

  // Index and logical device number
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      index_r <= KMLC_RST_BYTE;
      ldn_r   <= KMLC_RST_BYTE;
    end
    else if (ce)
    begin
      if (cfg_wr && !cfg_sel_data)
        index_r <= cfg_wdata;
      if (wr_ldn)
        ldn_r <= cfg_wdata;
    end
  end

  // Isolate bits survive host reset; only standby reset clears them
  // Writes are still refused while host reset is low, as for every register
  always_ff @(posedge clk)
  begin
    if (!standby_system_reset_n)
      iso_r <= 2'h0;
    else if (ce && rst_n && wr_iso)
      iso_r <= {cfg_wdata[KMLC_B_MISO], cfg_wdata[KMLC_B_KISO]};
  end

  // Host-domain registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl_r  <= 3'h0;
      swap_r <= KMLC_RST_BIT;
      crst_r <= KMLC_RST_BIT;
    end
    else if (ce)
    begin
      if (wr_iso)
        ctl_r <= {cfg_wdata[KMLC_B_MLSEL], cfg_wdata[KMLC_B_KLSEL],
                  cfg_wdata[KMLC_B_FGATE]};
      if (wr_swap)
        swap_r <= cfg_wdata[KMLC_B_SWAP];
      if (wr_rst)
        crst_r <= cfg_wdata[KMLC_B_CRST];
    end
  end

  // Read data is registered; it appears the edge after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cfg_rdata <= KMLC_RST_BYTE;
    else if (ce && cfg_rd)
      cfg_rdata <= rd_mux;
  end

  // ****************************************
  // Channels
  // ****************************************
  kmlc_chan_if kbd_if ();
  kmlc_chan_if mse_if ();

  // Isolation acts on the physical pins, before any swap
  assign kbd_if.pin_clk   = keyboard_clock_pin_in;
  assign kbd_if.pin_dat   = keyboard_data_pin_in;
  assign kbd_if.isolate   = iso_r[0];
  assign kbd_if.latch_sel = ctl_r[1];
  assign kbd_if.core_irq  = core_keyboard_interrupt;
  assign kbd_if.irq_ack   = core_kbd_irq_ack;
  assign mse_if.pin_clk   = mouse_clock_pin_in;
  assign mse_if.pin_dat   = mouse_data_pin_in;
  assign mse_if.isolate   = iso_r[1];
  assign mse_if.latch_sel = ctl_r[2];
  assign mse_if.core_irq  = core_mouse_interrupt;
  assign mse_if.irq_ack   = core_mouse_irq_ack;

  kmlc_chan u_kbd (.clk(clk), .rst_n(rst_n), .ce(ce), .ch(kbd_if));
  kmlc_chan u_mse (.clk(clk), .rst_n(rst_n), .ce(ce), .ch(mse_if));

  // Swap selection toward the core and toward the pins
  wire kbd_clk_core = swap_r ? mse_if.core_clk : kbd_if.core_clk;
  wire kbd_dat_core = swap_r ? mse_if.core_dat : kbd_if.core_dat;
  wire mse_clk_core = swap_r ? kbd_if.core_clk : mse_if.core_clk;
  wire mse_dat_core = swap_r ? kbd_if.core_dat : mse_if.core_dat;
  wire kbd_clk_drv  = swap_r ? core_mse_clk_drive : core_kbd_clk_drive;
  wire kbd_dat_drv  = swap_r ? core_mse_dat_drive : core_kbd_dat_drive;
  wire mse_clk_drv  = swap_r ? core_kbd_clk_drive : core_mse_clk_drive;
  wire mse_dat_drv  = swap_r ? core_kbd_dat_drive : core_mse_dat_drive;

  // ****************************************
  // Output flops
  // ****************************************
  // Open-drain pins only ever drive low, so the data outputs are constant flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      {keyboard_clock_pin_oe, keyboard_data_pin_oe} <= 2'h0;
      {mouse_clock_pin_oe, mouse_data_pin_oe}       <= 2'h0;
      {keyboard_clock_pin_out, keyboard_data_pin_out} <= 2'h0;
      {mouse_clock_pin_out, mouse_data_pin_out}       <= 2'h0;
      {core_kbd_clk_in, core_kbd_dat_in, core_mse_clk_in, core_mse_dat_in} <= 4'hf;
      {keyboard_interrupt, mouse_interrupt}         <= 2'h0;
      {keyboard_wake_data, mouse_wake_data}         <= 2'h3;
      fast_gate_enable <= KMLC_RST_BIT;
      core_reset       <= KMLC_RST_BIT;
    end
    else if (ce)
    begin
      keyboard_clock_pin_oe <= kbd_clk_drv;
      keyboard_data_pin_oe  <= kbd_dat_drv;
      mouse_clock_pin_oe    <= mse_clk_drv;
      mouse_data_pin_oe     <= mse_dat_drv;
      core_kbd_clk_in <= kbd_clk_core;
      core_kbd_dat_in <= kbd_dat_core;
      core_mse_clk_in <= mse_clk_core;
      core_mse_dat_in <= mse_dat_core;
      keyboard_interrupt <= kbd_if.irq;
      mouse_interrupt    <= mse_if.irq;
      // Wake data follows the physical pin, never isolated or swapped
      keyboard_wake_data <= kbd_if.wake_dat;
      mouse_wake_data    <= mse_if.wake_dat;
      fast_gate_enable <= ctl_r[0];
      core_reset       <= crst_r;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_mouse_iso_block: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && iso_r[1] && !swap_r) |=> (core_mse_clk_in && core_mse_dat_in))
    else $error("mouse pins reached core while isolated");
  chk_kbd_iso_block: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && iso_r[0] && !swap_r) |=> (core_kbd_clk_in && core_kbd_dat_in))
    else $error("keyboard pins reached core while isolated");
  // The pipeline holds reset values for three edges after host reset lifts
  chk_wake_mouse_free: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && $past(ce, 1) && $past(ce, 2) && $past(ce, 3) &&
     $past(rst_n, 1) && $past(rst_n, 2) && $past(rst_n, 3))
      |-> mouse_wake_data == $past(mouse_data_pin_in, 3))
    else $error("mouse wake data not following pin");
  chk_wake_kbd_free: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && $past(ce, 1) && $past(ce, 2) && $past(ce, 3) &&
     $past(rst_n, 1) && $past(rst_n, 2) && $past(rst_n, 3))
      |-> keyboard_wake_data == $past(keyboard_data_pin_in, 3))
    else $error("keyboard wake data not following pin");
  chk_mouse_irq_sel: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !ctl_r[2] && !core_mouse_interrupt) |=> !mouse_interrupt)
    else $error("mouse interrupt high without core interrupt");
  chk_kbd_irq_sel: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !ctl_r[1] && !core_keyboard_interrupt) |=> !keyboard_interrupt)
    else $error("keyboard interrupt high without core interrupt");
  chk_fast_gate_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr_iso) ##1 ce |=> fast_gate_enable == $past(cfg_wdata[KMLC_B_FGATE], 2))
    else $error("fast gate enable does not follow write");
  chk_swap_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && swap_r && core_mse_clk_drive) |=> keyboard_clock_pin_oe)
    else $error("swapped mouse clock drive missing on keyboard pin");
  chk_core_reset_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr_rst) ##1 ce |=> core_reset == $past(cfg_wdata[KMLC_B_CRST], 2))
    else $error("core reset does not follow write");
  chk_bank_select: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && dat_wr && !in_bank) |=> $stable(swap_r) && $stable(crst_r))
    else $error("register written outside its logical device");
endmodule : kmlc_top

// >>> verif/kmlc_ps2_dev_model.sv
// Behavioural PS/2 keyboard and mouse devices on the open-drain pin wires.
// Assumes the bench commands which lines each device pulls low.
`timescale 1ns/1ps
module kmlc_ps2_dev_model (
  input  wire logic       clk,     // Bench clock
  input  wire logic       slow,    // 1 = devices react one cycle late
  input  wire logic [3:0] oe,      // Block pulls kbd clk/dat, mouse clk/dat low
  input  wire logic [3:0] dev_low, // Devices want the same lines low
  output logic      [3:0] pin      // Resolved wire levels
);
  // ****************************************
  // Open-drain wires with pull-ups
  // ****************************************
  logic [3:0] held_r; // Delayed device request for slow replies

  // A slow device lags its command by one clock, as a real one may
  always_ff @(posedge clk)
  begin
    held_r <= dev_low;
  end

  // Released lines go high through the pull-up, never keep a stale value
  assign pin = ~(oe | (slow ? held_r : dev_low));
endmodule : kmlc_ps2_dev_model

// >>> verif/kmlc_top_test.sv
// Self-checking bench for the keyboard/mouse configuration block.
// Assumes one 200 MHz clock and the index/data port modelled by cfg_sel_data.
`timescale 1ns/1ps
module kmlc_top_test
  import kmlc_pkg::*;
;
  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  logic       clk = 1'b0;   // 200 MHz clock
  logic       rst_n = 1'b0; // Host domain reset
  logic       sby_n = 1'b0; // Standby reset
  logic       ce = 1'b1;    // Clock enable, low during one data write
  logic       cfg_wr = 1'b0, cfg_rd = 1'b0, cfg_sel_data = 1'b0;
  logic [7:0] cfg_wdata = 8'h00, cfg_rdata;
  logic [3:0] drv = 4'h0, dev_low = 4'h0, pin, oe, cin, pout; // Kbd clk/dat, mouse clk/dat
  logic [1:0] cirq = 2'b00, ack = 2'b00, irq, wake;           // {kbd,mouse}
  logic       fge, crst, rd_d = 1'b0;
  logic [7:0] exp_q[$];     // Expected read data, oldest first
  logic [31:0] v;
  int         num_errors = 0, tests_run = 0, cyc = 0;

  always #2.5 clk = ~clk;

  kmlc_top u_kmlc_top (.clk(clk), .rst_n(rst_n), .standby_system_reset_n(sby_n), .ce(ce),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_sel_data(cfg_sel_data), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .keyboard_clock_pin_in(pin[3]), .keyboard_data_pin_in(pin[2]),
    .mouse_clock_pin_in(pin[1]), .mouse_data_pin_in(pin[0]),
    .keyboard_clock_pin_out(pout[3]), .keyboard_clock_pin_oe(oe[3]),
    .keyboard_data_pin_out(pout[2]), .keyboard_data_pin_oe(oe[2]),
    .mouse_clock_pin_out(pout[1]), .mouse_clock_pin_oe(oe[1]),
    .mouse_data_pin_out(pout[0]), .mouse_data_pin_oe(oe[0]),
    .core_kbd_clk_drive(drv[3]), .core_kbd_dat_drive(drv[2]),
    .core_mse_clk_drive(drv[1]), .core_mse_dat_drive(drv[0]),
    .core_kbd_clk_in(cin[3]), .core_kbd_dat_in(cin[2]), .core_mse_clk_in(cin[1]),
    .core_mse_dat_in(cin[0]), .core_keyboard_interrupt(cirq[1]),
    .core_mouse_interrupt(cirq[0]), .core_kbd_irq_ack(ack[1]), .core_mouse_irq_ack(ack[0]),
    .keyboard_interrupt(irq[1]), .mouse_interrupt(irq[0]), .keyboard_wake_data(wake[1]),
    .mouse_wake_data(wake[0]), .fast_gate_enable(fge), .core_reset(crst));

  kmlc_ps2_dev_model u_kmlc_ps2_dev_model (.clk(clk), .slow(v[9]), .oe(oe),
    .dev_low(dev_low), .pin(pin));

  // ****************************************
  // Compare, report and port tasks
  // ****************************************
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_lvl(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected level at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_lvl

  task automatic end_sim;
    if (num_errors == 0 && tests_run > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // One strobe, then an idle edge so the next call never re-drives in the same step
  task automatic wr(input logic sel, input logic [7:0] d);
    cfg_wr <= 1'b1;
    cfg_sel_data <= sel;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic sel, input logic [7:0] e);
    exp_q.push_back(e);
    cfg_rd <= 1'b1;
    cfg_sel_data <= sel;
    @(posedge clk);
    cfg_rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : rd

  task automatic regw(input logic [7:0] ofs, input logic [7:0] d);
    wr(1'b0, ofs);
    wr(1'b1, d);
  endtask : regw

  task automatic regr(input logic [7:0] ofs, input logic [7:0] e);
    wr(1'b0, ofs);
    rd(1'b1, e);
  endtask : regr

  // ****************************************
  // Read monitor and hang guard
  // ****************************************
  // Read data is due one edge after the strobe is taken
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      cmp_rd(cfg_rdata, exp_q.pop_front());
    end
    rd_d <= cfg_rd;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    v = $urandom(32'h9aeb);
    v = 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    sby_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmp_lvl(cin, 4'hf);
    regw(KMLC_OFS_RST, 8'h01);              // Dropped: no device selected
    repeat (3) @(posedge clk);
    cmp_lvl({2'b00, fge, crst}, 4'h0);
    regw(KMLC_IDX_LDN, KMLC_LDN_KBD);
    regr(KMLC_OFS_ISO, 8'h00);
    regr(KMLC_OFS_SWAP, 8'h00);
    regr(KMLC_OFS_RST, 8'h00);
    rd(1'b0, KMLC_OFS_RST);
    regr(8'hf3, 8'h00);
    // Clock enable low freezes every register, so this data write is lost
    wr(1'b0, KMLC_OFS_RST);
    ce <= 1'b0;
    wr(1'b1, 8'h01);
    ce <= 1'b1;
    rd(1'b1, 8'h00);
    // Random settings with reserved bits written as zero
    repeat (6)
    begin
      v = $urandom;
      regw(KMLC_OFS_ISO, v[7:0] & 8'h7c);
      regw(KMLC_OFS_SWAP, {7'h00, v[0]});
      regw(KMLC_OFS_RST, {7'h00, v[8]});
      repeat (2) @(posedge clk);
      cmp_lvl({2'b00, fge, crst}, {2'b00, v[2], v[8]});
      regr(KMLC_OFS_ISO, v[7:0] & 8'h7c);
      regr(KMLC_OFS_SWAP, {7'h00, v[0]});
      regr(KMLC_OFS_RST, {7'h00, v[8]});
    end
    // Host reset keeps the isolate pair; only the standby reset clears it
    regw(KMLC_OFS_ISO, 8'h7c);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    regw(KMLC_IDX_LDN, KMLC_LDN_KBD);
    regr(KMLC_OFS_ISO, 8'h60);
    sby_n <= 1'b0;
    repeat (2) @(posedge clk);
    sby_n <= 1'b1;
    @(posedge clk);
    regr(KMLC_OFS_ISO, 8'h00);
    // Every isolate and swap combination toward the core; drives to the pins only with both isolates off
    for (int s = 0; s < 8; s++)
    begin
      regw(KMLC_OFS_ISO, {1'b0, s[1], s[0], 5'h00});
      regw(KMLC_OFS_SWAP, {7'h00, s[2]});
      repeat (3)
      begin
        v = $urandom;
        dev_low <= v[3:0];
        repeat (6) @(posedge clk);
        cmp_lvl(cin, s[2] ? {s[1] ? 2'b11 : ~v[1:0], s[0] ? 2'b11 : ~v[3:2]}
                          : {s[0] ? 2'b11 : ~v[3:2], s[1] ? 2'b11 : ~v[1:0]});
        cmp_lvl({2'b00, wake}, {2'b00, ~v[2], ~v[0]});
        if (s[1:0] == 2'b00)
        begin
          dev_low <= 4'h0;
          drv <= v[7:4];
          repeat (3) @(posedge clk);
          cmp_lvl(oe, s[2] ? {v[5:4], v[7:6]} : v[7:4]);
          cmp_lvl(pout, 4'h0);
          drv <= 4'h0;
        end
      end
    end
    dev_low <= 4'h0;
    // Interrupt selection in both latch modes
    for (int ls = 0; ls < 2; ls++)
    begin
      regw(KMLC_OFS_ISO, {3'b000, ls[0], ls[0], 3'b000});
      cirq <= 2'b11;
      repeat (4) @(posedge clk);
      cmp_lvl({2'b00, irq}, 4'h3);
      cirq <= 2'b00;
      repeat (4) @(posedge clk);
      cmp_lvl({2'b00, irq}, ls[0] ? 4'h3 : 4'h0);
      ack <= 2'b11;
      @(posedge clk);
      ack <= 2'b00;
      repeat (3) @(posedge clk);
      cmp_lvl({2'b00, irq}, 4'h0);
    end
    end_sim();
  end
endmodule : kmlc_top_test
